//--- disable_pkg.sv
// Shared constants and types for the device disable link
package disable_pkg;

	// Link power states reported by the device end
	typedef enum logic [1:0]
	{
		LINK_L0 = 2'b00,
		LINK_L3 = 2'b11
	} link_state_t;

	// Device disable controller states
	typedef enum logic [1:0]
	{
		DEV_POWERUP = 2'b00,
		DEV_ACTIVE = 2'b01,
		DEV_DISABLED = 2'b10
	} dev_state_t;

	// Firmware end states
	typedef enum logic [2:0]
	{
		FW_IDLE = 3'b000,
		FW_WAIT_LINK = 3'b001,
		FW_DISABLED = 3'b010,
		FW_ENUM = 3'b011,
		FW_ENABLED = 3'b100
	} fw_state_t;

	// Pin levels and synchronizer reset value
	localparam logic REQ_ENABLE_LEVEL = 1'b1;
	localparam logic REQ_DISABLE_LEVEL = 1'b0;
	localparam logic [1:0] SYNC_RESET = 2'h3;

endpackage : disable_pkg

//--- disable_if.sv
// Interface joining the firmware end and the device end
`timescale 1ns/1ns
interface disable_if;
	import disable_pkg::*;

	// Disable request pin, driven by firmware
	logic disable_request_n_o;
	logic disable_request_n_oe;
	logic disable_request_n;
	// Fundamental reset and power good from the platform
	logic pcie_fundamental_reset_n;
	logic host_power_good;
	// Device status
	logic link_up;

	// Pull-up: an undriven pin reads as enable
	assign disable_request_n = disable_request_n_oe ?
		disable_request_n_o : REQ_ENABLE_LEVEL;

	modport device
	(
		input disable_request_n,
		input pcie_fundamental_reset_n,
		output link_up
	);

	modport firmware
	(
		output disable_request_n_o,
		output disable_request_n_oe,
		output pcie_fundamental_reset_n,
		output host_power_good,
		input link_up
	);

endinterface : disable_if

//--- dev_disable_ctrl.sv
// Device end of the device disable controller
`timescale 1ns/1ns
module dev_disable_ctrl
	import disable_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_B_I,
	// Link side
	disable_if.device LINK,
	// Configuration store handshake
	output logic CFG_LOAD_REQ_O,
	input wire logic CFG_LOAD_DONE_I,
	// Status to the core
	output logic DISABLED_O,
	output logic [1:0] LINK_STATE_O,
	output logic PHY_POWER_DOWN_O,
	output logic OUTPUT_ENABLE_O
);

	typedef struct packed
	{
		logic [1:0] sync;
		dev_state_t state;
		logic rst_seen;
		logic cfg_req;
		logic disabled;
		logic [1:0] link_state;
		logic phy_pd;
		logic out_en;
		logic link_up;
	} dev_regs_t;

	dev_regs_t r_r;
	dev_regs_t r_nxt;
	logic req_active;

	////////////////////////////////////////////////////////////////
	// Second stage only feeds the state logic
	assign req_active = (r_r.sync[1] == REQ_DISABLE_LEVEL);

	always_comb
	begin
		r_nxt = r_r;
		// Pull-up lives in the interface, so a floating pin is 1
		r_nxt.sync = {r_r.sync[0], LINK.disable_request_n};
		case (r_r.state)
			DEV_POWERUP:
			begin
				// Request ignored until the store has been read
				r_nxt.cfg_req = 1'b1;
				if (CFG_LOAD_DONE_I)
				begin
					r_nxt.cfg_req = 1'b0;
					if (req_active)
						r_nxt.state = DEV_DISABLED;
					else
						r_nxt.state = DEV_ACTIVE;
				end
			end
			DEV_ACTIVE:
			begin
				if (!LINK.pcie_fundamental_reset_n)
					r_nxt.rst_seen = 1'b1;
				else if (r_r.rst_seen)
				begin
					// Reset released: reload the store before deciding
					r_nxt.rst_seen = 1'b0;
					r_nxt.state = DEV_POWERUP;
				end
				else if (req_active)
					r_nxt.state = DEV_DISABLED;
			end
			DEV_DISABLED:
			begin
				// Fundamental reset has no effect here
				r_nxt.rst_seen = 1'b0;
				if (!req_active)
					r_nxt.state = DEV_POWERUP;
			end
			default:
				r_nxt.state = DEV_POWERUP;
		endcase
		r_nxt.disabled = (r_nxt.state == DEV_DISABLED);
		r_nxt.link_state = r_nxt.disabled ? LINK_L3 : LINK_L0;
		r_nxt.phy_pd = r_nxt.disabled;
		r_nxt.out_en = !r_nxt.disabled;
		r_nxt.link_up = (r_nxt.state == DEV_ACTIVE);
	end

	always_ff @(posedge CLOCK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			r_r.sync <= SYNC_RESET;
			r_r.state <= DEV_POWERUP;
			r_r.rst_seen <= 1'b0;
			r_r.cfg_req <= 1'b0;
			r_r.disabled <= 1'b0;
			r_r.link_state <= LINK_L0;
			r_r.phy_pd <= 1'b1;
			r_r.out_en <= 1'b0;
			r_r.link_up <= 1'b0;
		end
		else
			r_r <= r_nxt;
	end

	////////////////////////////////////////////////////////////////
	assign CFG_LOAD_REQ_O = r_r.cfg_req;
	assign DISABLED_O = r_r.disabled;
	assign LINK_STATE_O = r_r.link_state;
	assign PHY_POWER_DOWN_O = r_r.phy_pd;
	assign OUTPUT_ENABLE_O = r_r.out_en;
	assign LINK.link_up = r_r.link_up;

endmodule : dev_disable_ctrl

//--- fw_disable_ctrl.sv
// Firmware end driving the disable request pin
`timescale 1ns/1ns
module fw_disable_ctrl
	import disable_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_B_I,
	// Link side
	disable_if.firmware LINK,
	// User commands
	input wire logic POWER_GOOD_I,
	input wire logic FUND_RESET_N_I,
	input wire logic DISABLE_CMD_I,
	input wire logic ENABLE_CMD_I,
	// Status
	output logic ENUM_START_O,
	output logic DEVICE_OFF_O
);

	typedef struct packed
	{
		fw_state_t state;
		logic req_n;
		logic enum_start;
		logic off;
		logic pg;
		logic frst_n;
	} fw_regs_t;

	fw_regs_t r_r;
	fw_regs_t r_nxt;

	////////////////////////////////////////////////////////////////
	always_comb
	begin
		r_nxt = r_r;
		r_nxt.enum_start = 1'b0;
		r_nxt.pg = POWER_GOOD_I;
		r_nxt.frst_n = FUND_RESET_N_I;
		case (r_r.state)
			FW_IDLE:
				if (r_r.pg)
					r_nxt.state = FW_WAIT_LINK;
			FW_WAIT_LINK:
				// Only disable once the link is up
				if (LINK.link_up && DISABLE_CMD_I)
				begin
					r_nxt.req_n = REQ_DISABLE_LEVEL;
					r_nxt.off = 1'b1;
					r_nxt.state = FW_DISABLED;
				end
			FW_DISABLED:
			begin
				// Functions are gone; enumeration finds nothing
				// Link is left in L3; far-end electrical idle is optional
				r_nxt.enum_start = 1'b1;
				r_nxt.state = FW_ENUM;
			end
			FW_ENUM:
				if (ENABLE_CMD_I)
				begin
					r_nxt.req_n = REQ_ENABLE_LEVEL;
					r_nxt.off = 1'b0;
					r_nxt.state = FW_ENABLED;
				end
			FW_ENABLED:
				if (LINK.link_up)
				begin
					r_nxt.enum_start = 1'b1;
					r_nxt.state = FW_WAIT_LINK;
				end
			default:
				r_nxt.state = FW_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			r_r.state <= FW_IDLE;
			// Default is the enable level, loaded again on every reset
			r_r.req_n <= REQ_ENABLE_LEVEL;
			r_r.enum_start <= 1'b0;
			r_r.off <= 1'b0;
			r_r.pg <= 1'b0;
			r_r.frst_n <= 1'b0;
		end
		else
			r_r <= r_nxt;
	end

	////////////////////////////////////////////////////////////////
	assign LINK.disable_request_n_o = r_r.req_n;
	assign LINK.disable_request_n_oe = 1'b1;
	assign LINK.host_power_good = r_r.pg;
	assign LINK.pcie_fundamental_reset_n = r_r.frst_n;
	assign ENUM_START_O = r_r.enum_start;
	assign DEVICE_OFF_O = r_r.off;

endmodule : fw_disable_ctrl

//--- disable_sva.sv
// Checker on the wires between firmware end and device end
`timescale 1ns/1ns
module disable_sva
(
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_B_I,
	// Link wires
	input wire logic disable_request_n_oe,
	input wire logic disable_request_n,
	input wire logic pcie_fundamental_reset_n,
	input wire logic host_power_good,
	input wire logic link_up
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RST_B_I);
	////////////////////////////////////////////////////////////
	sequence s_low4;
		!disable_request_n[*4];
	endsequence
	sequence s_fund_up;
		$rose(pcie_fundamental_reset_n);
	endsequence
	a_pin_pull_up: assert property (!disable_request_n_oe |->
		disable_request_n) else $error("pin not pulled up");
	a_pin_held: assert property (disable_request_n_oe)
		else $error("pin left floating");
	a_off_drops_link: assert property (s_low4 |-> !link_up)
		else $error("link still up");
	a_off_after_up: assert property ($fell(disable_request_n) |->
		$past(link_up) && host_power_good) else $error("early off");
	a_on_from_off: assert property ($rose(disable_request_n) |->
		$past(link_up) == 1'b0) else $error("enable while up");
	a_on_rereads: assert property ($rose(disable_request_n) |->
		!link_up[*3]) else $error("no store read");
	a_fund_no_wake: assert property (s_fund_up and !disable_request_n
		|-> !link_up[*4]) else $error("reset woke device");
	// Only a release seen while the link is up forces a store re-read
	a_fund_reboot: assert property (s_fund_up and (disable_request_n && link_up)
		|-> ##[1:3] !link_up) else $error("no reboot");
	a_off_stays: assert property (!disable_request_n && !link_up
		|=> !link_up) else $error("woke while off");
endmodule : disable_sva

//--- tb.sv
// Bench joining both ends of the disable link
`timescale 1ns/1ns
module tb;
	import disable_pkg::*;
	logic clk = 0, rd = 0, rf = 0, done = 0, pg = 0, frst = 1, dc = 0, ec = 0;
	logic cfg, dis, phy, oe, es, off;
	logic [1:0] lst;
	int n_fail = 0, n_compared = 0;
	disable_if lnk();
	dev_disable_ctrl i_dev_disable_ctrl(.CLOCK_I(clk), .RST_B_I(rd),
		.LINK(lnk), .CFG_LOAD_REQ_O(cfg), .CFG_LOAD_DONE_I(done),
		.DISABLED_O(dis), .LINK_STATE_O(lst), .PHY_POWER_DOWN_O(phy),
		.OUTPUT_ENABLE_O(oe));
	fw_disable_ctrl i_fw_disable_ctrl(.CLOCK_I(clk), .RST_B_I(rf),
		.LINK(lnk), .POWER_GOOD_I(pg), .FUND_RESET_N_I(frst),
		.DISABLE_CMD_I(dc), .ENABLE_CMD_I(ec), .ENUM_START_O(es),
		.DEVICE_OFF_O(off));
	disable_sva i_disable_sva(.CLOCK_I(clk), .RST_B_I(rd & rf),
		.disable_request_n_oe(lnk.disable_request_n_oe),
		.disable_request_n(lnk.disable_request_n),
		.pcie_fundamental_reset_n(lnk.pcie_fundamental_reset_n),
		.host_power_good(lnk.host_power_good), .link_up(lnk.link_up));
	initial
	begin
		forever #25 clk = ~clk;
	end
	////////////////////////////////////////////////////////////
	// Inputs move 2 ns after the edge, so outputs are settled too
	task automatic cy(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : cy
	task automatic wrap_up;
		$display("n_fail=%0d n_compared=%0d", n_fail, n_compared);
		if (n_fail == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [2:0] g, input logic [2:0] e);
		n_compared++;
		if (g !== e)
		begin
			n_fail++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic til(ref logic s, input logic v);
		for (int i = 0; i < 20 && s !== v; i++)
			cy(1);
		if (s !== v)
		begin
			n_fail++;
			wrap_up();
		end
	endtask : til
	task automatic load;
		til(cfg, 1'b1);
		done = 1'b1;
		cy(1);
		done = 1'b0;
	endtask : load
	////////////////////////////////////////////////////////////
	task automatic t_boot;
		chk({dis, phy, oe}, 3'h2);
		rd = 1'b1;
		rf = 1'b1;
		pg = 1'b1;
		dc = 1'b1;
		cy(1);
		dc = 1'b0;
		chk(lnk.disable_request_n, 3'h1);
		load();
		til(lnk.link_up, 1'b1);
		chk({dis, phy, oe}, 3'h1);
		chk(lst, LINK_L0);
		$display("boot ok");
	endtask : t_boot
	task automatic t_off;
		dc = 1'b1;
		cy(1);
		dc = 1'b0;
		chk({lnk.disable_request_n, off}, 3'h1);
		til(es, 1'b1);
		til(dis, 1'b1);
		chk({lnk.link_up, phy, oe}, 3'h2);
		chk(lst, LINK_L3);
		frst = 1'b0;
		cy(3);
		frst = 1'b1;
		cy(4);
		chk({dis, cfg}, 3'h2);
		$display("off ok");
	endtask : t_off
	// Device alone is reset, so the pin stays low across power-up
	task automatic t_powerup;
		rd = 1'b0;
		cy(1);
		rd = 1'b1;
		cy(4);
		chk({dis, cfg}, 3'h1);
		load();
		til(dis, 1'b1);
		chk(lst, LINK_L3);
		$display("powerup ok");
	endtask : t_powerup
	task automatic t_on;
		ec = 1'b1;
		cy(1);
		ec = 1'b0;
		chk({lnk.disable_request_n, off}, 3'h2);
		load();
		til(es, 1'b1);
		chk({lnk.link_up, phy, oe}, 3'h5);
		frst = 1'b0;
		cy(2);
		frst = 1'b1;
		til(cfg, 1'b1);
		chk({lnk.link_up, dis}, 3'h0);
		$display("on ok");
	endtask : t_on
	initial
	begin
		cy(2);
		t_boot();
		t_off();
		t_powerup();
		t_on();
		wrap_up();
	end
endmodule : tb
